// ### rfm_rod_fault_monitor.sv
// Operation
// [RQ1] one asymmetry monitor per rod, 69 rods
// [RQ2] absolute rod-to-group difference, silent below setpoint
// [RQ3] two channels: 7 and 9 inch thresholds
// [RQ4] lower fault: rod lamp, computer, annunciator alarm
// [RQ5] upper fault lights console asymmetric lamp
// [RQ6] manual mode: no cutback request
// [RQ7] automatic mode: upper fault requests power cutback
// [RQ8] coordinating system caps demand at 55 percent
// [RQ9] coordinating system holds cap until fault corrected; model drops cap once cutbackReq falls, as on leaving auto
// [RQ10] asymmetric fault raises withdrawal block
// [RQ11] below-60-percent bypass cancels withdrawal block
// [RQ12] same action for stuck or dropped rods
// [RQ13] group averages checked against allowed sequence
// [RQ14] per-group out-of-turn enable evaluated
// [RQ15] out of sequence in auto: manual, alarm
// [RQ16] stay manual until cleared and operator reset
// [RQ17] any tripped device or channel alarms
// [RQ18] automatic only with all four safety groups out
// [RQ19] sensor faults flow through asymmetry monitor
// [RQ20] fault indicators latch until operator clears
// [RQ21] equal counts as not exceeded; thresholds configurable
`include "rfm_cfg.svh"

module rfm_rod_fault_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic posValid,
    input wire logic [`RFM_ROD_IW-1:0] posRod,
    input wire logic [`RFM_POS_W-1:0] rodPos,
    input wire logic [`RFM_POS_W-1:0] groupAvg,
    input wire logic bypassBelow60,
    input wire logic [`RFM_TRIP_DEV_N-1:0] tripDevice,
    input wire logic [`RFM_TRIP_CH_N-1:0] tripChannel,
    input wire logic [`RFM_SAFETY_N-1:0] safetyOutLimit,
    input wire logic [`RFM_GRP_N-1:0] groupMoving,
    input wire logic [`RFM_GRP_N-1:0] groupEnable,
    output logic [`RFM_ROD_N-1:0] rodFaultLamp,
    output logic asymAlarm,
    output logic consoleAsymLamp,
    output logic cutbackReq,
    output logic withdrawBlock,
    output logic autoMode,
    output logic seqAlarmLamp,
    output logic tripAnnunciator,
    output logic safetyNotOutLamp,
    output logic autoPermit
);
    rfm_pkg::rfm_state_t st_q;
    rfm_pkg::rfm_state_t st_d;
    rfm_mem_if memIf ();

    // ======================================================
    // helpers
    function automatic logic [`RFM_POS_W-1:0] absDiff(
        input logic [`RFM_POS_W-1:0] a,
        input logic [`RFM_POS_W-1:0] b);
        absDiff = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [31:0] mergeBytes(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        mergeBytes = r;
    endfunction

    // ======================================================
    // synchronised pins, second stage only
    logic bypass;
    logic [`RFM_TRIP_DEV_N-1:0] tripDevS;
    logic [`RFM_TRIP_CH_N-1:0] tripChS;
    logic [`RFM_SAFETY_N-1:0] safetyS;
    logic [`RFM_GRP_N-1:0] movingS;
    logic [`RFM_GRP_N-1:0] enableS;
    logic [`RFM_POS_W-1:0] sepNow;
    logic rodOk;
    logic permit;
    logic outSeq;
    logic busWr;
    logic ctrlWr;
    logic autoReq;
    logic manualReq;
    logic clearEv;
    logic seqResetEv;
    logic selOk;

    assign bypass = st_q.pinS2[`RFM_PIN_BYP_BIT];
    assign tripDevS = st_q.pinS2[`RFM_PIN_TDV_LSB +: `RFM_TRIP_DEV_N];
    assign tripChS = st_q.pinS2[`RFM_PIN_TCH_LSB +: `RFM_TRIP_CH_N];
    assign safetyS = st_q.pinS2[`RFM_PIN_SAF_LSB +: `RFM_SAFETY_N];
    assign movingS = st_q.pinS2[`RFM_PIN_MOV_LSB +: `RFM_GRP_N];
    assign enableS = st_q.pinS2[`RFM_PIN_GEN_LSB +: `RFM_GRP_N];

    assign sepNow = absDiff(rodPos, groupAvg); // RQ2
    assign rodOk = posValid && (posRod < `RFM_ROD_LIMIT); // RQ1
    assign permit = &safetyS; // RQ18
    // moving off turn without enable is a sequence fault
    assign outSeq = |(movingS & ~(st_q.turnMask | enableS)); // RQ13 RQ14
    assign busWr = write && (st_q.phase == rfm_pkg::RFM_BUS_ACK);
    assign ctrlWr = busWr && address == `RFM_REG_CTRL && byteenable[0];
    assign autoReq = ctrlWr && writedata[`RFM_CTRL_AUTO];
    assign manualReq = ctrlWr && writedata[`RFM_CTRL_MANUAL];
    assign clearEv = ctrlWr && writedata[`RFM_CTRL_CLEAR];
    assign seqResetEv = ctrlWr && writedata[`RFM_CTRL_SEQRST];
    assign selOk = st_q.rodSel < `RFM_ROD_LIMIT;

    // ======================================================
    // separation readback store
    assign memIf.wr = rodOk;
    assign memIf.wAddr = posRod;
    assign memIf.wData = sepNow;
    assign memIf.rAddr = st_q.rodSel;

    rfm_sep_mem uMem (
        .clk(clk),
        .resetn(resetn),
        .port(memIf)
    );

    // ======================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.pinS1 = {bypassBelow60, tripDevice, tripChannel,
            safetyOutLimit, groupMoving, groupEnable};
        st_d.pinS2 = st_q.pinS1;

        // sensor faults need no path of their own: a bad reading
        // simply shows up as separation here
        if (rodOk) begin
            st_d.cur7[posRod] = sepNow > st_q.thrLow; // RQ3 RQ21 RQ19
            st_d.cur9[posRod] = sepNow > st_q.thrUp; // RQ3 RQ21 RQ12
        end
        // set beats clear; a live condition refuses the clear
        st_d.lat7 = st_d.cur7 | (clearEv ? '0 : st_q.lat7); // RQ20
        st_d.lat9 = st_d.cur9 | (clearEv ? '0 : st_q.lat9); // RQ20

        if (st_q.autoMode && outSeq) begin
            st_d.seqLock = 1'b1; // RQ15
        end else if (seqResetEv && !outSeq) begin
            st_d.seqLock = 1'b0; // RQ16
        end
        if (outSeq || !permit || manualReq) begin
            st_d.autoMode = 1'b0; // RQ15 RQ18
        end else if (autoReq && !st_q.seqLock) begin
            st_d.autoMode = 1'b1; // RQ16
        end

        st_d.faultLamps = st_d.lat7; // RQ4
        st_d.alarmOut = |st_d.lat7; // RQ4
        st_d.consoleLamp = |st_d.lat9; // RQ5
        // demand cap is held outside while this stays up
        st_d.cutback = st_q.autoMode && |st_d.lat9; // RQ6 RQ7 RQ9
        st_d.withdrawBlock = |st_d.lat9 && !bypass; // RQ10 RQ11
        st_d.seqAlarm = st_d.seqLock; // RQ15
        st_d.tripAnn = |tripDevS || |tripChS; // RQ17
        st_d.safetyLamp = !permit; // RQ18
        st_d.autoPermit = permit && !st_d.seqLock; // RQ18 RQ14

        // fixed two-cycle answer keeps the memory read simple
        case (st_q.phase)
            rfm_pkg::RFM_BUS_IDLE: begin
                if (read || write) begin
                    st_d.phase = rfm_pkg::RFM_BUS_WAIT;
                end
            end
            rfm_pkg::RFM_BUS_WAIT: begin
                st_d.phase = rfm_pkg::RFM_BUS_ACK;
                st_d.waitreq = 1'b0;
                st_d.readdata = '0;
                if (read) begin
                    case (address)
                        `RFM_REG_STATUS: begin
                            st_d.readdata[7:0] = {autoPermit,
                                safetyNotOutLamp, tripAnnunciator,
                                withdrawBlock, cutbackReq,
                                consoleAsymLamp, st_q.seqLock,
                                st_q.autoMode};
                        end
                        `RFM_REG_THR_LOW: begin
                            st_d.readdata[`RFM_POS_W-1:0] = st_q.thrLow;
                        end
                        `RFM_REG_THR_UP: begin
                            st_d.readdata[`RFM_POS_W-1:0] = st_q.thrUp;
                        end
                        `RFM_REG_TURN: begin
                            st_d.readdata[`RFM_GRP_N-1:0] = st_q.turnMask;
                        end
                        `RFM_REG_SEL: begin
                            st_d.readdata[`RFM_ROD_IW-1:0] = st_q.rodSel;
                        end
                        `RFM_REG_SEP: begin
                            st_d.readdata[`RFM_POS_W-1:0] = memIf.rData;
                            st_d.readdata[`RFM_SEP_LAT7_BIT] =
                                selOk && st_q.lat7[st_q.rodSel];
                            st_d.readdata[`RFM_SEP_LAT9_BIT] =
                                selOk && st_q.lat9[st_q.rodSel];
                        end
                        default: begin
                            st_d.readdata = '0;
                        end
                    endcase
                end
            end
            rfm_pkg::RFM_BUS_ACK: begin
                st_d.phase = rfm_pkg::RFM_BUS_IDLE;
                st_d.waitreq = 1'b1;
                if (busWr) begin
                    case (address)
                        `RFM_REG_THR_LOW: begin
                            st_d.thrLow = `RFM_POS_W'(mergeBytes(
                                32'(st_q.thrLow), writedata,
                                byteenable)); // RQ21
                        end
                        `RFM_REG_THR_UP: begin
                            st_d.thrUp = `RFM_POS_W'(mergeBytes(
                                32'(st_q.thrUp), writedata,
                                byteenable)); // RQ21
                        end
                        `RFM_REG_TURN: begin
                            st_d.turnMask = `RFM_GRP_N'(mergeBytes(
                                32'(st_q.turnMask), writedata, byteenable));
                        end
                        `RFM_REG_SEL: begin
                            st_d.rodSel = `RFM_ROD_IW'(mergeBytes(
                                32'(st_q.rodSel), writedata, byteenable));
                        end
                        default: begin
                            st_d.rodSel = st_q.rodSel;
                        end
                    endcase
                end
            end
            default: begin
                st_d.phase = rfm_pkg::RFM_BUS_IDLE;
                st_d.waitreq = 1'b1;
            end
        endcase
    end

    // ======================================================
    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.thrLow <= `RFM_THR_LOW_RST;
            st_q.thrUp <= `RFM_THR_UP_RST;
            st_q.turnMask <= `RFM_TURN_RST;
            st_q.waitreq <= 1'b1;
            st_q.phase <= rfm_pkg::RFM_BUS_IDLE;
            st_q.safetyLamp <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign readdata = st_q.readdata;
    assign waitrequest = st_q.waitreq;
    assign rodFaultLamp = st_q.faultLamps;
    assign asymAlarm = st_q.alarmOut;
    assign consoleAsymLamp = st_q.consoleLamp;
    assign cutbackReq = st_q.cutback;
    assign withdrawBlock = st_q.withdrawBlock;
    assign autoMode = st_q.autoMode;
    assign seqAlarmLamp = st_q.seqAlarm;
    assign tripAnnunciator = st_q.tripAnn;
    assign safetyNotOutLamp = st_q.safetyLamp;
    assign autoPermit = st_q.autoPermit;

    // ======================================================
    // checks
    a_low_alarm: assert property (@(posedge clk) disable iff (!resetn) // RQ4
        rodOk && sepNow > st_q.thrLow
        |=> rodFaultLamp[$past(posRod)] && asymAlarm)
        else $error("lower separation did not light rod lamp");

    a_equal_quiet: assert property (@(posedge clk) disable iff (!resetn) // RQ21
        rodOk && sepNow == st_q.thrUp && !st_q.lat9[posRod]
        |=> !st_q.lat9[$past(posRod)])
        else $error("separation equal to threshold raised fault");

    a_console_lamp: assert property (@(posedge clk) disable iff (!resetn) // RQ5
        |st_q.lat9 && !clearEv |=> consoleAsymLamp)
        else $error("console lamp off during upper fault");

    a_manual_nocut: assert property (@(posedge clk) disable iff (!resetn) // RQ6
        !st_q.autoMode |=> !cutbackReq)
        else $error("cutback requested in manual mode");

    a_auto_cutback: assert property (@(posedge clk) disable iff (!resetn) // RQ7
        st_q.autoMode && |st_q.lat9 && !clearEv |=> cutbackReq)
        else $error("no cutback for upper fault in auto");

    a_block_bypass: assert property (@(posedge clk) disable iff (!resetn) // RQ11
        bypass |=> !withdrawBlock)
        else $error("withdrawal block while bypassed");

    a_seq_drop: assert property (@(posedge clk) disable iff (!resetn) // RQ15
        st_q.autoMode && outSeq |=> !autoMode && st_q.seqLock ##1 seqAlarmLamp)
        else $error("out of sequence did not force manual");

    a_seq_hold: assert property (@(posedge clk) disable iff (!resetn) // RQ16
        st_q.seqLock && !seqResetEv |=> st_q.seqLock && !st_q.autoMode)
        else $error("sequence lock left without reset");

    a_trip_ann: assert property (@(posedge clk) disable iff (!resetn) // RQ17
        (|tripDevS || |tripChS) |=> tripAnnunciator)
        else $error("trip state not annunciated");

    a_safety_perm: assert property (@(posedge clk) disable iff (!resetn) // RQ18
        !permit |=> !autoMode && !autoPermit)
        else $error("automatic allowed with safety rods in");

    a_latch_hold: assert property (@(posedge clk) disable iff (!resetn) // RQ20
        !clearEv |=> (st_q.lat7 & $past(st_q.lat7)) == $past(st_q.lat7))
        else $error("fault latch dropped without clear");

    a_bus_answer: assert property (@(posedge clk) disable iff (!resetn)
        (read || write) && st_q.phase == rfm_pkg::RFM_BUS_IDLE
        |=> waitrequest ##1 !waitrequest ##1 waitrequest)
        else $error("bus answer not two cycles");
endmodule

// ### rfm_cfg.svh
`ifndef RFM_CFG_SVH
`define RFM_CFG_SVH

// ==========================================================
// geometry
`define RFM_ROD_N 69
`define RFM_ROD_LIMIT 7'h45
`define RFM_ROD_IW 7
`define RFM_POS_W 10
`define RFM_GRP_N 8
`define RFM_SAFETY_N 4
`define RFM_TRIP_CH_N 4
`define RFM_TRIP_DEV_N 8
`define RFM_MEM_DEPTH 128

// ==========================================================
// thresholds, position units of 0.1 inch
`define RFM_THR_LOW_RST 10'h046
`define RFM_THR_UP_RST 10'h05a

// ==========================================================
// synchronised pin vector layout
`define RFM_PIN_W 33
`define RFM_PIN_GEN_LSB 0
`define RFM_PIN_MOV_LSB 8
`define RFM_PIN_SAF_LSB 16
`define RFM_PIN_TCH_LSB 20
`define RFM_PIN_TDV_LSB 24
`define RFM_PIN_BYP_BIT 32

// ==========================================================
// register word offsets
`define RFM_REG_CTRL 3'h0
`define RFM_REG_STATUS 3'h1
`define RFM_REG_THR_LOW 3'h2
`define RFM_REG_THR_UP 3'h3
`define RFM_REG_TURN 3'h4
`define RFM_REG_SEL 3'h5
`define RFM_REG_SEP 3'h6

// ==========================================================
// control bits, write one to act
`define RFM_CTRL_AUTO 0
`define RFM_CTRL_MANUAL 1
`define RFM_CTRL_CLEAR 2
`define RFM_CTRL_SEQRST 3

// ==========================================================
// readback field positions, turn mask reset value
`define RFM_SEP_LAT7_BIT 16
`define RFM_SEP_LAT9_BIT 17
`define RFM_TURN_RST 8'hff

`endif

// ### rfm_pkg.sv
`include "rfm_cfg.svh"

package rfm_pkg;

    // gray along idle -> wait -> ack
    typedef enum logic [1:0] {
        RFM_BUS_IDLE = 2'h0,
        RFM_BUS_WAIT = 2'h1,
        RFM_BUS_ACK = 2'h3
    } rfm_bus_t;

    typedef struct packed {
        logic [`RFM_PIN_W-1:0] pinS1;
        logic [`RFM_PIN_W-1:0] pinS2;
        logic [`RFM_ROD_N-1:0] cur7;
        logic [`RFM_ROD_N-1:0] cur9;
        logic [`RFM_ROD_N-1:0] lat7;
        logic [`RFM_ROD_N-1:0] lat9;
        logic [`RFM_POS_W-1:0] thrLow;
        logic [`RFM_POS_W-1:0] thrUp;
        logic [`RFM_GRP_N-1:0] turnMask;
        logic [`RFM_ROD_IW-1:0] rodSel;
        logic autoMode;
        logic seqLock;
        rfm_bus_t phase;
        logic waitreq;
        logic [31:0] readdata;
        logic [`RFM_ROD_N-1:0] faultLamps;
        logic alarmOut;
        logic consoleLamp;
        logic cutback;
        logic withdrawBlock;
        logic seqAlarm;
        logic tripAnn;
        logic safetyLamp;
        logic autoPermit;
    } rfm_state_t;

    typedef struct packed {
        logic [`RFM_MEM_DEPTH-1:0][`RFM_POS_W-1:0] mem;
        logic [`RFM_POS_W-1:0] rData;
    } rfm_mem_t;

endpackage

// ### rfm_mem_if.sv
`include "rfm_cfg.svh"

interface rfm_mem_if;
    logic wr;
    logic [`RFM_ROD_IW-1:0] wAddr;
    logic [`RFM_POS_W-1:0] wData;
    logic [`RFM_ROD_IW-1:0] rAddr;
    logic [`RFM_POS_W-1:0] rData;

    modport user (output wr, output wAddr, output wData, output rAddr,
        input rData);
    modport store (input wr, input wAddr, input wData, input rAddr,
        output rData);
endinterface

// ### rfm_sep_mem.sv
`include "rfm_cfg.svh"

module rfm_sep_mem (
    input wire logic clk,
    input wire logic resetn,
    rfm_mem_if.store port
);
    rfm_pkg::rfm_mem_t st_q;
    rfm_pkg::rfm_mem_t st_d;

    // ======================================================
    // separation store, registered read
    always_comb begin
        st_d = st_q;
        if (port.wr) begin
            st_d.mem[port.wAddr] = port.wData;
        end
        st_d.rData = st_q.mem[port.rAddr];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign port.rData = st_q.rData;

    a_mem_readback: assert property (@(posedge clk) disable iff (!resetn)
        port.wr && port.rAddr == port.wAddr ##1 port.rAddr == $past(port.rAddr)
        |=> port.rData == $past(port.wData, 2))
        else $error("separation readback mismatch");
endmodule

// ### rfm_plant_model.sv
// ==========================================================
// plant coordinating system at the far side of the monitor
module rfm_plant_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] powerPct,
    input wire logic cutbackReq,
    output logic bypassBelow60,
    output logic [7:0] demandCap
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic byp;
        logic [7:0] cap;
    } rfm_plant_t;
    rfm_plant_t st_q;
    rfm_plant_t st_d;
    always_comb begin
        st_d = st_q;
        st_d.byp = powerPct < 8'h3c;
        // cap follows the request, so it holds until the upper fault latch clears or auto mode ends
        st_d.cap = cutbackReq ? 8'h37 : 8'h64;
        if (!resetn) begin
            st_d.byp = 1'b0;
            st_d.cap = 8'h64;
        end
    end
    always_ff @(posedge clk) begin
        st_q <= st_d;
    end
    assign bypassBelow60 = st_q.byp;
    assign demandCap = st_q.cap;
endmodule

// ### rfm_rod_fault_monitor_tb.sv
`include "rfm_cfg.svh"
module rfm_rod_fault_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic posValid = 1'b0;
    logic [6:0] posRod = 7'h0;
    logic [9:0] rodPos = 10'h0;
    logic [9:0] groupAvg = 10'h0;
    logic [7:0] powerPct = 8'h64;
    logic [7:0] tripDevice = 8'h0;
    logic [3:0] tripChannel = 4'h0;
    logic [3:0] safetyOutLimit = 4'h0;
    logic [7:0] groupMoving = 8'h0;
    logic [7:0] groupEnable = 8'h0;
    logic [`RFM_ROD_N-1:0] rodFaultLamp;
    logic bypassBelow60, asymAlarm, consoleAsymLamp, cutbackReq;
    logic withdrawBlock, autoMode, seqAlarmLamp, tripAnnunciator;
    logic safetyNotOutLamp, autoPermit;
    logic [7:0] demandCap;
    // ==========================================================
    // reference model state
    bit [68:0] l7, l9, c7, c9;
    bit am, sl;
    int tl = 70;
    int tu = 90;
    bit [7:0] tm = 8'hff;
    int error_cnt = 0;
    int n_tests = 0;
    rfm_rod_fault_monitor uut (.clk(clk), .resetn(resetn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .posValid(posValid), .posRod(posRod),
        .rodPos(rodPos), .groupAvg(groupAvg),
        .bypassBelow60(bypassBelow60), .tripDevice(tripDevice),
        .tripChannel(tripChannel), .safetyOutLimit(safetyOutLimit),
        .groupMoving(groupMoving), .groupEnable(groupEnable),
        .rodFaultLamp(rodFaultLamp), .asymAlarm(asymAlarm),
        .consoleAsymLamp(consoleAsymLamp), .cutbackReq(cutbackReq),
        .withdrawBlock(withdrawBlock), .autoMode(autoMode),
        .seqAlarmLamp(seqAlarmLamp), .tripAnnunciator(tripAnnunciator),
        .safetyNotOutLamp(safetyNotOutLamp), .autoPermit(autoPermit));
    rfm_plant_model plant (.clk(clk), .resetn(resetn),
        .powerPct(powerPct), .cutbackReq(cutbackReq),
        .bypassBelow60(bypassBelow60), .demandCap(demandCap));
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // tasks
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [68:0] e,
        input logic [68:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic bit outSeq();
        return |(groupMoving & ~(tm | groupEnable));
    endfunction
    task automatic check();
        bit saf;
        saf = safetyOutLimit == 4'hf;
        chk("lamps", l7, rodFaultLamp);
        chk("alarm", |l7, asymAlarm);
        chk("console", |l9, consoleAsymLamp);
        chk("cutback", am & |l9, cutbackReq);
        chk("block", |l9 & (powerPct >= 60), withdrawBlock);
        chk("auto", am, autoMode);
        chk("seqLamp", sl, seqAlarmLamp);
        chk("trip", |{tripDevice, tripChannel}, tripAnnunciator);
        chk("notOut", !saf, safetyNotOutLamp);
        chk("permit", saf & !sl, autoPermit);
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input bit w, input logic [2:0] a,
        input logic [31:0] d, output logic [31:0] q);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        @(posedge clk);
        // only the watchdog ends a wait that never gets its answer
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ctrl(input int b);
        logic [31:0] q;
        bus(1, 3'h0, 32'h1 << b, q);
        case (b)
            0: if (!sl && safetyOutLimit == 4'hf && !outSeq()) am = 1;
            1: am = 0;
            2: begin
                l7 &= c7;
                l9 &= c9;
            end
            default: if (!outSeq()) sl = 0;
        endcase
        @(posedge clk);
        check();
    endtask
    // two sync flops, output register, plus the plant's own flop
    task automatic pins();
        repeat (5) @(posedge clk);
        if (am && outSeq()) begin
            am = 0;
            sl = 1;
        end
        if (safetyOutLimit != 4'hf) am = 0;
        check();
    endtask
    task automatic pos(input int r, input int p, input int g);
        int d;
        posValid <= 1'b1;
        posRod <= 7'(r);
        rodPos <= 10'(p);
        groupAvg <= 10'(g);
        @(posedge clk);
        posValid <= 1'b0;
        d = p > g ? p - g : g - p;
        if (r < 69) begin
            c7[r] = d > tl;
            c9[r] = d > tu;
            l7[r] = l7[r] | c7[r];
            l9[r] = l9[r] | c9[r];
        end
        repeat (2) @(posedge clk);
        check();
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] q;
        int regExp[8];
        regExp = '{0, 64, 70, 90, 255, 0, 0, 0};
        void'($urandom(32'h3f6c9b0f));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        check();
        bus(1, 3'h1, 32'hff, q);
        bus(1, 3'h7, 32'hffffffff, q);
        for (int a = 0; a < 8; a++) begin
            bus(0, 3'(a), 32'h0, q);
            chk("reg", 69'(regExp[a]), 69'(q));
        end
        safetyOutLimit <= 4'hf;
        pins();
        ctrl(0);
        pos(5, 200, 300);
        bus(1, 3'h5, 32'h5, q);
        bus(0, 3'h6, 32'h0, q);
        chk("sep", 69'h30064, 69'(q));
        tl = 40 + $urandom_range(29);
        bus(1, 3'h2, 32'(tl), q);
        for (int i = 0; i < 40; i++) begin
            int r, g, dv;
            r = (i % 10 == 9) ? 100 : $urandom_range(68);
            g = 200 + $urandom_range(300);
            case ($urandom_range(5))
                0: dv = tl;
                1: dv = tl + 1;
                2: dv = tu;
                3: dv = tu + 1;
                4: dv = $urandom_range(200);
                default: dv = g;
            endcase
            if (i == 20) ctrl(1);
            if ($urandom_range(1) == 1 && dv != g) dv = -dv;
            pos(r, g - dv, g);
        end
        powerPct <= 8'h32;
        pins();
        powerPct <= 8'h64;
        pins();
        ctrl(2);
        for (int r = 0; r < 69; r++) pos(r, 100, 100);
        ctrl(2);
        for (int i = 0; i < 12; i++) begin
            tripDevice <= i < 8 ? 8'h1 << i : 8'h0;
            tripChannel <= i < 8 ? 4'h0 : 4'h1 << (i - 8);
            pins();
        end
        tripChannel <= 4'h0;
        ctrl(0);
        bus(1, 3'h4, 32'h1, q);
        tm = 8'h01;
        groupMoving <= 8'h02;
        pins();
        ctrl(0);
        ctrl(3);
        groupEnable <= 8'h02;
        pins();
        ctrl(0);
        ctrl(3);
        ctrl(0);
        safetyOutLimit <= 4'h7;
        pins();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule
